// File: hw/ssl_host.sv
// Host end: APB-programmed serial master that loads the device latches.
//
// How it works
// - Device shifts one bit per rising clock.
// - Strobe rise copies word to chosen latch.
// - Serial clock never exceeds 20 MHz.
// - Strobe goes low before shifting starts.
// - Three bytes sent; strobe rises afterwards.
// - Data changes on falling edge, except the first bit at start.
// - Power-up loads: init, function, reference, feedback.
// - Host line drives chip power enable.
// - Status output carries lock, host polls.
// - Divider value one is accepted.
// - Low two bits pick destination latch.
// - Power enable low powers down immediately.
// - Init load resets counters, first feedback too.
`timescale 1ns/1ps
module ssl_host (
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clken,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt.
    output logic irq,
    // Link.
    ssl_link_if.host link
);
    import ssl_pkg::*;

    ssl_state_t state_q;
    logic [DIV_W-1:0] div_q;
    logic tick;
    logic [BIT_CNT_W-1:0] bits_q;
    logic [WORD_W-1:0] sh_q;
    logic [WORD_W-1:0] word_q;
    logic pwr_q;
    logic sclk_q;
    logic sdata_q;
    logic strobe_q;
    logic [2:0] seq_q;
    logic seq_done;
    logic lock_lvl;
    logic lock_rise;
    logic [IRQ_W-1:0] stat_q;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] ev_set;
    logic apb_acc;
    logic apb_wr;
    logic go_req;
    logic go_ok;
    logic go_bad;
    logic hit;
    logic [31:0] rd_d;
    logic [SEL_W-1:0] exp_sel;

    assign link.sclk = sclk_q;
    assign link.sdata = sdata_q;
    assign link.load_strobe = strobe_q;
    assign link.chip_pwr_en = pwr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Lock status returns from another domain and is synchronised.
    ssl_sync #(.W(1)) u_lock_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clken(clken),
        .din(link.multiplexed_status_output),
        .level(lock_lvl),
        .rise(lock_rise)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // APB access; every access waits one cycle and answers on the second.
    assign apb_acc = psel && penable && pready;
    assign apb_wr = apb_acc && pwrite && hit;
    assign go_req = apb_wr && paddr[7:0] == OFS_CTRL && pwdata[CTRL_GO_BIT];

    always_comb begin
        hit = 1'b1;
        rd_d = 32'h00000000;
        if (paddr[31:8] != 24'h000000) begin
            hit = 1'b0;
        end else if (paddr[7:0] == OFS_CTRL) begin
            rd_d[CTRL_PWR_BIT] = pwr_q;
        end else if (paddr[7:0] == OFS_WORD) begin
            rd_d[WORD_W-1:0] = word_q;
        end else if (paddr[7:0] == OFS_STATUS) begin
            rd_d[ST_BUSY_BIT] = state_q != SSL_IDLE;
            rd_d[ST_LOCK_BIT] = lock_lvl;
            rd_d[ST_READY_BIT] = seq_done;
        end else if (paddr[7:0] == OFS_IRQ_STAT) begin
            rd_d[IRQ_W-1:0] = stat_q;
        end else if (paddr[7:0] == OFS_IRQ_MASK) begin
            rd_d[IRQ_W-1:0] = mask_q;
        end else begin
            hit = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (clken) begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit;
            prdata <= (psel && penable && !pready && !pwrite) ? rd_d : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= CTRL_PWR_RST;
            word_q <= WORD_RST;
            mask_q <= IRQ_MASK_RST;
        end else if (clken && apb_wr) begin
            if (paddr[7:0] == OFS_CTRL) begin
                pwr_q <= pwdata[CTRL_PWR_BIT];
            end else if (paddr[7:0] == OFS_WORD) begin
                word_q <= pwdata[WORD_W-1:0];
            end else if (paddr[7:0] == OFS_IRQ_MASK) begin
                mask_q <= pwdata[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power-up load order; words out of order are refused until it completes.
    always_comb begin
        case (seq_q)
            3'h0: exp_sel = SEL_INIT;
            3'h1: exp_sel = SEL_FUNC;
            3'h2: exp_sel = SEL_REF;
            default: exp_sel = SEL_FB;
        endcase
    end

    assign seq_done = seq_q == 3'(LOAD_SEQ_LEN);
    assign go_ok = go_req && state_q == SSL_IDLE && (seq_done || word_q[SEL_W-1:0] == exp_sel);
    assign go_bad = go_req && state_q == SSL_IDLE && !go_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q <= 3'h0;
        end else if (clken && state_q == SSL_LOAD && tick && !seq_done) begin
            seq_q <= seq_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Half-period divider keeps the serial clock within its limit.
    assign tick = div_q == DIV_LAST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else if (clken) begin
            if (state_q == SSL_IDLE || tick) begin
                div_q <= '0;
            end else begin
                div_q <= div_q + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Word transfer: strobe low, 24 bits MSB first as three bytes, strobe high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SSL_IDLE;
            bits_q <= '0;
            sh_q <= WORD_RST;
            sclk_q <= 1'b0;
            sdata_q <= 1'b0;
            strobe_q <= 1'b0;
        end else if (clken) begin
            case (state_q)
                SSL_IDLE: begin
                    if (go_ok) begin
                        strobe_q <= 1'b0;
                        sh_q <= word_q;
                        sdata_q <= word_q[WORD_W-1];
                        bits_q <= '0;
                        state_q <= SSL_DROP;
                    end
                end
                SSL_DROP: begin
                    if (tick) begin
                        state_q <= SSL_SHIFT;
                    end
                end
                SSL_SHIFT: begin
                    if (tick && !sclk_q) begin
                        sclk_q <= 1'b1;
                    end else if (tick) begin
                        sclk_q <= 1'b0;
                        if (bits_q == BIT_LAST) begin
                            state_q <= SSL_LOAD;
                        end else begin
                            bits_q <= bits_q + 5'h01;
                            sh_q <= {sh_q[WORD_W-2:0], 1'b0};
                            sdata_q <= sh_q[WORD_W-2];
                        end
                    end
                end
                SSL_LOAD: begin
                    strobe_q <= 1'b1;
                    if (tick) begin
                        state_q <= SSL_IDLE;
                    end
                end
                default: begin
                    state_q <= SSL_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky events, cleared by writing one; a new event beats the clear.
    always_comb begin
        ev_set = '0;
        ev_set[IRQ_DONE_BIT] = state_q == SSL_LOAD && tick;
        ev_set[IRQ_LOCK_BIT] = lock_rise;
        ev_set[IRQ_ORDER_BIT] = go_bad;
        ev_set[IRQ_SEQ_BIT] = state_q == SSL_LOAD && tick && seq_q == 3'(LOAD_SEQ_LEN - 1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
            irq <= 1'b0;
        end else if (clken) begin
            if (apb_wr && paddr[7:0] == OFS_IRQ_STAT) begin
                stat_q <= (stat_q & ~pwdata[IRQ_W-1:0]) | ev_set;
            end else begin
                stat_q <= stat_q | ev_set;
            end
            irq <= |(stat_q & mask_q);
        end
    end
endmodule // ssl_host

// File: shared/ssl_pkg.sv
// Shared constants and types of the serial latch loader link.
package ssl_pkg;
    localparam int unsigned WORD_W = 24;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned SEL_W = 2;
    // Destination codes in the two lowest bits of a word.
    localparam logic [SEL_W-1:0] SEL_REF = 2'h0;
    localparam logic [SEL_W-1:0] SEL_FB = 2'h1;
    localparam logic [SEL_W-1:0] SEL_FUNC = 2'h2;
    localparam logic [SEL_W-1:0] SEL_INIT = 2'h3;
    localparam int unsigned LOAD_SEQ_LEN = 4;
    // Serial clock timing.
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SCLK_MAX_HZ = 20_000_000;
    localparam int unsigned SCLK_HALF_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
    localparam int unsigned DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF_CYC - 1);
    localparam int unsigned BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = BIT_CNT_W'(WORD_W - 1);
    // Controller register offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_WORD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    // Control and status field positions.
    localparam int unsigned CTRL_PWR_BIT = 0;
    localparam int unsigned CTRL_GO_BIT = 1;
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_LOCK_BIT = 1;
    localparam int unsigned ST_READY_BIT = 2;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_LOCK_BIT = 1;
    localparam int unsigned IRQ_ORDER_BIT = 2;
    localparam int unsigned IRQ_SEQ_BIT = 3;
    // Values after reset.
    localparam logic CTRL_PWR_RST = 1'b0;
    localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    typedef enum logic [3:0] {
        SSL_IDLE = 4'h1,
        SSL_DROP = 4'h2,
        SSL_SHIFT = 4'h4,
        SSL_LOAD = 4'h8
    } ssl_state_t;
endpackage

// File: shared/ssl_link_if.sv
// Three-wire programming link with power enable and status return.
`timescale 1ns/1ps
interface ssl_link_if;
    logic sclk;
    logic sdata;
    logic load_strobe;
    logic chip_pwr_en;
    logic multiplexed_status_output;
    modport host (
        output sclk,
        output sdata,
        output load_strobe,
        output chip_pwr_en,
        input multiplexed_status_output
    );
    modport dev (
        input sclk,
        input sdata,
        input load_strobe,
        input chip_pwr_en,
        output multiplexed_status_output
    );
endinterface

// File: hw/ssl_sync.sv
// Three-stage input synchroniser with agreement filter and rise pulse.
`timescale 1ns/1ps
module ssl_sync #(
    parameter int unsigned W = 1
) (
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clken,
    // Raw inputs and filtered results.
    input wire logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    level[i] <= 1'b0;
                    rise[i] <= 1'b0;
                end else if (clken) begin
                    s1_q <= din[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // A change counts once the second and third stages agree.
                    if (s2_q == s3_q) begin
                        level[i] <= s2_q;
                    end
                    rise[i] <= (s2_q == s3_q) && s2_q && !level[i];
                end
            end
        end
    endgenerate
endmodule // ssl_sync

// File: hw/ssl_dev.sv
// Device end: serial shift register, destination latches and power control.
`timescale 1ns/1ps
module ssl_dev (
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clken,
    // Link.
    ssl_link_if.dev link,
    // User side.
    input wire logic lock_in,
    output logic [ssl_pkg::WORD_W-1:0] init_latch,
    output logic [ssl_pkg::WORD_W-1:0] func_latch,
    output logic [ssl_pkg::WORD_W-1:0] ref_latch,
    output logic [ssl_pkg::WORD_W-1:0] fb_latch,
    output logic cnt_reset_pulse,
    output logic powered_down,
    output logic output_active
);
    import ssl_pkg::*;

    logic [3:0] lvl;
    logic [3:0] rse;
    logic [WORD_W-1:0] sh_q;
    logic fb_rearm_q;
    logic [LOAD_SEQ_LEN-1:0] loaded_q;
    logic status_q;
    logic [SEL_W-1:0] latch_select_bits;

    assign latch_select_bits = sh_q[SEL_W-1:0];
    assign link.multiplexed_status_output = status_q;

    ////////////////////////////////////////////////////////////////////////////////
    ssl_sync #(.W(4)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clken(clken),
        .din({link.chip_pwr_en, link.load_strobe, link.sdata, link.sclk}),
        .level(lvl),
        .rise(rse)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Older bits fall off the top, so only the latest word survives.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= WORD_RST;
        end else if (clken && rse[0]) begin
            sh_q <= {sh_q[WORD_W-2:0], lvl[1]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divider values of one are stored as given; no code is rejected.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_latch <= WORD_RST;
            func_latch <= WORD_RST;
            ref_latch <= WORD_RST;
            fb_latch <= WORD_RST;
            loaded_q <= '0;
        end else if (clken && rse[2]) begin
            case (latch_select_bits)
                SEL_REF: begin
                    ref_latch <= sh_q;
                    loaded_q[2] <= 1'b1;
                end
                SEL_FB: begin
                    fb_latch <= sh_q;
                    loaded_q[3] <= 1'b1;
                end
                SEL_FUNC: begin
                    func_latch <= sh_q;
                    loaded_q[1] <= 1'b1;
                end
                default: begin
                    init_latch <= sh_q;
                    func_latch <= sh_q;
                    loaded_q[0] <= 1'b1;
                    loaded_q[1] <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter reset pulse on an init load and on the first feedback load after it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reset_pulse <= 1'b0;
            fb_rearm_q <= 1'b0;
        end else if (clken) begin
            cnt_reset_pulse <= 1'b0;
            if (rse[2] && latch_select_bits == SEL_INIT) begin
                cnt_reset_pulse <= 1'b1;
                fb_rearm_q <= 1'b1;
            end else if (rse[2] && latch_select_bits == SEL_FB && fb_rearm_q) begin
                cnt_reset_pulse <= 1'b1;
                fb_rearm_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power enable acts with no serial clock; latch contents survive power-down.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered_down <= 1'b1;
            output_active <= 1'b0;
            status_q <= 1'b0;
        end else if (clken) begin
            powered_down <= !lvl[3];
            output_active <= (&loaded_q) && lvl[3];
            status_q <= lock_in;
        end
    end
endmodule // ssl_dev

// File: test/ssl_link_props.sv
// Link-side assertions of the serial latch loader.
`timescale 1ns/1ps
module ssl_link_props (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Link.
    input wire logic sclk,
    input wire logic sdata,
    input wire logic load_strobe,
    input wire logic chip_pwr_en,
    input wire logic multiplexed_status_output
);
    import ssl_pkg::*;
    localparam int FRAME_MIN = 90;
    localparam int FRAME_MAX = 110;
    localparam logic [1:0] ORDER [4] = '{SEL_INIT, SEL_FUNC, SEL_REF, SEL_FB};
    logic sclk_q;
    logic strobe_q;
    logic [5:0] rise_q;
    logic [WORD_W-1:0] word_q;
    logic [2:0] frame_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // Mirror of what the device shifts in since the strobe fell.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 1'b0;
            strobe_q <= 1'b0;
            rise_q <= 6'h00;
            word_q <= 24'h000000;
            frame_q <= 3'h0;
        end else begin
            sclk_q <= sclk;
            strobe_q <= load_strobe;
            if (load_strobe) begin
                rise_q <= 6'h00;
            end else if (sclk && !sclk_q) begin
                rise_q <= rise_q + 6'h01;
            end
            if (sclk && !sclk_q) begin
                word_q <= {word_q[WORD_W-2:0], sdata};
            end
            if (load_strobe && !strobe_q && frame_q < 3'h4) begin
                frame_q <= frame_q + 3'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence s_high_half;
        sclk ##1 !sclk;
    endsequence
    sequence s_lead_in;
        !sclk [*2];
    endsequence
    sequence s_frame_end;
        ##[FRAME_MIN:FRAME_MAX] $rose(load_strobe);
    endsequence
    rate_high_a: assert property ($rose(sclk) |=> s_high_half) else $error("sclk high half too short");
    rate_low_a: assert property ($fell(sclk) |=> !sclk) else $error("sclk low half too short");
    data_hold_a: assert property ($changed(sdata) |-> !sclk) else $error("sdata moved while sclk high");
    strobe_low_a: assert property (sclk |-> !load_strobe) else $error("shift while strobe high");
    lead_in_a: assert property ($fell(load_strobe) |-> s_lead_in) else $error("shift began with strobe");
    frame_len_a: assert property ($fell(load_strobe) |-> s_frame_end) else $error("frame length wrong");
    bit_count_a: assert property ($rose(load_strobe) |-> rise_q == 6'h18) else $error("not 24 bits");
    load_order_a: assert property ($rose(load_strobe) && frame_q < 3'h4 |-> word_q[1:0] == ORDER[frame_q[1:0]])
        else $error("power-up order broken");
endmodule // ssl_link_props

// File: test/tb_synth_serial_latch_loader.sv
// Self-checking bench joining the host and device ends of the serial latch loader.
`timescale 1ns/1ps
module tb_synth_serial_latch_loader;
    import ssl_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clken = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd_q;
    logic pready, pslverr, irq, err_q, pwr_q;
    logic lock_in = 1'b0;
    logic [WORD_W-1:0] init_latch, func_latch, ref_latch, fb_latch, ref2_latch;
    logic cnt_reset_pulse, powered_down, output_active;
    int err_total = 0;
    int n_checks = 0;
    int pulses = 0;
    ssl_link_if link ();
    ssl_link_if link2 ();
    always #10 pclk = ~pclk;
    always @(posedge pclk) if (cnt_reset_pulse === 1'b1) pulses <= pulses + 1;
    ssl_host ssl_host_inst (.pclk(pclk), .presetn(presetn), .clken(clken), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .link(link));
    ssl_dev ssl_dev_inst (.pclk(pclk), .presetn(presetn), .clken(clken), .link(link), .lock_in(lock_in),
        .init_latch(init_latch), .func_latch(func_latch), .ref_latch(ref_latch), .fb_latch(fb_latch),
        .cnt_reset_pulse(cnt_reset_pulse), .powered_down(powered_down), .output_active(output_active));
    // Second device end fed by the bench, for overlong shifts.
    ssl_dev ssl_dev_fault_inst (.pclk(pclk), .presetn(presetn), .clken(clken), .link(link2), .lock_in(1'b0),
        .init_latch(), .func_latch(), .ref_latch(ref2_latch), .fb_latch(), .cnt_reset_pulse(),
        .powered_down(), .output_active());
    ssl_link_props ssl_link_props_inst (.pclk(pclk), .presetn(presetn), .sclk(link.sclk), .sdata(link.sdata),
        .load_strobe(link.load_strobe), .chip_pwr_en(link.chip_pwr_en),
        .multiplexed_status_output(link.multiplexed_status_output));
    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            err_total++;
            stop_test();
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Starts one word and waits until the host is idle and the device has synced.
    task automatic send(input logic [WORD_W-1:0] w);
        int i;
        apb(1'b1, OFS_WORD, {8'h00, w});
        apb(1'b1, OFS_CTRL, {30'h0, 1'b1, pwr_q});
        for (i = 0; i < 60; i++) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (rd_q[ST_BUSY_BIT] === 1'b0) break;
        end
        if (i == 60) begin
            err_total++;
            stop_test();
        end
        repeat (12) @(posedge pclk);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd_q);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk("ctrl", OFS_CTRL, 32'h0);
        rd_chk("mask", OFS_IRQ_MASK, 32'h0);
        rd_chk("word", OFS_WORD, 32'h0);
        chk("down", 32'h1, {31'h0, powered_down});
        chk("active", 32'h0, {31'h0, output_active});
        rd_chk("unmapped", 8'h14, 32'h0);
        chk("slverr", 32'h1, {31'h0, err_q});
    endtask
    task automatic t_order();
        send(24'h00F0F2);
        rd_chk("order irq", OFS_IRQ_STAT, 32'h4);
        chk("func early", 32'h0, {8'h00, func_latch});
        apb(1'b1, OFS_IRQ_STAT, 32'h4);
        rd_chk("irq clear", OFS_IRQ_STAT, 32'h0);
    endtask
    task automatic t_powerup();
        pwr_q = 1'b1;
        apb(1'b1, OFS_CTRL, 32'h1);
        repeat (10) @(posedge pclk);
        chk("up", 32'h0, {31'h0, powered_down});
        send(24'hC3A5A7);
        chk("init", 32'hC3A5A7, {8'h00, init_latch});
        chk("init func", 32'hC3A5A7, {8'h00, func_latch});
        chk("pulse init", 32'h1, pulses);
        send(24'h00F0F2);
        chk("func", 32'h00F0F2, {8'h00, func_latch});
        send(24'h000004);
        chk("ref one", 32'h000004, {8'h00, ref_latch});
        chk("early active", 32'h0, {31'h0, output_active});
        send(24'h000101);
        chk("fb one", 32'h000101, {8'h00, fb_latch});
        chk("pulse fb", 32'h2, pulses);
        rd_chk("seq irq", OFS_IRQ_STAT, 32'h9);
        chk("active", 32'h1, {31'h0, output_active});
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("ready", 32'h1, {31'h0, rd_q[ST_READY_BIT]});
        send(24'h000201);
        chk("fb again", 32'h000201, {8'h00, fb_latch});
        chk("no pulse", 32'h2, pulses);
    endtask
    task automatic t_irq();
        apb(1'b1, OFS_IRQ_STAT, 32'hF);
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        send(24'h000008);
        chk("irq on", 32'h1, {31'h0, irq});
        chk("ref", 32'h000008, {8'h00, ref_latch});
        apb(1'b1, OFS_IRQ_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq off", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        send(24'h00000C);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk("done stat", OFS_IRQ_STAT, 32'h1);
    endtask
    task automatic t_lock();
        // With the clock enable low the status output must not follow the lock input.
        clken <= 1'b0;
        lock_in <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("frozen status", 32'h0, {31'h0, link.multiplexed_status_output});
        clken <= 1'b1;
        repeat (12) @(posedge pclk);
        chk("status pin", 32'h1, {31'h0, link.multiplexed_status_output});
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("lock bit", 32'h1, {31'h0, rd_q[ST_LOCK_BIT]});
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("lock irq", 32'h1, {31'h0, rd_q[IRQ_LOCK_BIT]});
        lock_in <= 1'b0;
    endtask
    task automatic t_pwrdown();
        pwr_q = 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0);
        repeat (8) @(posedge pclk);
        chk("down", 32'h1, {31'h0, powered_down});
        chk("inactive", 32'h0, {31'h0, output_active});
        chk("kept", 32'h000201, {8'h00, fb_latch});
    endtask
    // Bench acts as a host that shifts 26 bits at a 160 ns serial period.
    task automatic t_overlong(input logic [25:0] w);
        link2.load_strobe <= 1'b0;
        for (int i = 25; i >= 0; i--) begin
            link2.sdata <= w[i];
            repeat (4) @(posedge pclk);
            link2.sclk <= 1'b1;
            repeat (4) @(posedge pclk);
            link2.sclk <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        link2.load_strobe <= 1'b1;
        link2.sdata <= ~w[0];
        repeat (12) @(posedge pclk);
        chk("last 24", {8'h00, w[23:0]}, {8'h00, ref2_latch});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        pwr_q = 1'b0;
        link2.sclk = 1'b0;
        link2.sdata = 1'b0;
        link2.load_strobe = 1'b1;
        link2.chip_pwr_en = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        t_reset();
        t_order();
        t_powerup();
        t_irq();
        t_lock();
        t_pwrdown();
        t_overlong({2'b11, 24'h5A5A58});
        stop_test();
    end
    initial begin
        repeat (90000) @(posedge pclk);
        err_total++;
        stop_test();
    end
endmodule // tb_synth_serial_latch_loader
